// ### hw/pts_pkg.sv
// Package for the period timer with scalers: register map, field layout,
// reset values and carrier types.
// Assumes one 100 MHz system clock and a plain strobe register port.
package pts_pkg;

  // ==========================================================================
  // Register offsets (word index on the plain port)
  localparam logic [2:0] PTS_OFF_COUNT   = 3'h0;
  localparam logic [2:0] PTS_OFF_PERIOD  = 3'h1;
  localparam logic [2:0] PTS_OFF_CONTROL = 3'h2;
  localparam logic [2:0] PTS_OFF_STATUS  = 3'h3;
  localparam logic [2:0] PTS_OFF_MASK    = 3'h4;

  // ==========================================================================
  // Control field positions
  localparam int PTS_PRE_LSB  = 0;
  localparam int PTS_ON_BIT   = 2;
  localparam int PTS_POST_LSB = 3;
  localparam int PTS_POST_MSB = 6;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] PTS_COUNT_RST   = 8'h00;
  localparam logic [7:0] PTS_PERIOD_RST  = 8'hff;
  localparam logic [7:0] PTS_CONTROL_RST = 8'h00;
  localparam logic [7:0] PTS_CONTROL_WMASK = 8'h7f;

  // ==========================================================================
  // Timing: instruction clock is the system clock divided by four
  localparam int         PTS_INSN_DIV = 4;
  localparam logic [1:0] PTS_INSN_LAST = 2'(PTS_INSN_DIV - 1);

  // Prescale ratios, as terminal counts of a 4-bit prescale counter
  localparam logic [3:0] PTS_PRE_LAST_1  = 4'h0;
  localparam logic [3:0] PTS_PRE_LAST_4  = 4'h3;
  localparam logic [3:0] PTS_PRE_LAST_16 = 4'hf;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pts_bus_req_t;

  typedef struct packed {
    logic [3:0] postscale_select;
    logic       timer_on;
    logic [1:0] prescale_select;
  } pts_ctrl_t;

endpackage

// ### hw/pts_scaler.sv
// Reusable event divider: counts input pulses and fires one pulse each
// time the count reaches a programmable terminal value.
// Assumes a synchronous clear that wins over counting.
`timescale 1ns/1ps
module pts_scaler (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [3:0] last,
  output logic            fire
);
  import pts_pkg::*;

  logic [3:0] cnt;
  logic [3:0] next_cnt;

  // ==========================================================================
  // Counter
  always_comb begin
    next_cnt = cnt;
    fire     = 1'b0;
    if (clear) begin
      next_cnt = 4'h0;
    end else if (tick) begin
      if (cnt >= last) begin
        // A terminal lowered below the count still fires at once
        next_cnt = 4'h0;
        fire     = 1'b1;
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

// ### hw/pts_timer.sv
// Period timer with prescaler and postscaler, register slave on a plain
// strobe port, sticky status with mask and one level interrupt.
// Assumes strobes are one cycle, never both at once, synchronous to clk_sys.
//
// Notes on behaviour
// - Counts only instruction clock through the prescaler
// - Count from zero, wraps after period match
// - Each match advances the postscaler once
// - Postscale ratio is select value plus one
// - Postscaler output sets the match interrupt flag
// - Reset loads count 00h, period FFh
// - Count and period fully readable and writable
// - Timer-on bit starts and stops the timer
// - Count or control writes clear both scalers
// - Control write leaves the count unchanged
// - Control layout 6-3 post, 2 on, 1-0 pre
`timescale 1ns/1ps
module pts_timer (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire pts_pkg::pts_bus_req_t bus_req,
  output logic [7:0]                rdata,
  output logic                      match_pulse,
  output logic                      match_interrupt_flag,
  output logic                      irq
);
  import pts_pkg::*;

  // ==========================================================================
  // State
  pts_ctrl_t  ctrl;
  pts_ctrl_t  next_ctrl;
  logic [7:0] timer_count;
  logic [7:0] next_count;
  logic [7:0] period_value;
  logic [7:0] next_period;
  logic [1:0] insn_cnt;
  logic [1:0] next_insn;
  logic       status;
  logic       next_status;
  logic       mask;
  logic       next_mask;
  logic [7:0] next_rdata;

  logic       wr_count;
  logic       wr_period;
  logic       wr_control;
  logic       scaler_clear;
  logic       insn_tick;
  logic       pre_fire;
  logic       post_fire;
  logic       at_period;
  logic [3:0] pre_last;

  function automatic logic hit(input pts_bus_req_t r,
                               input logic [2:0]   off);
    hit = r.wr && (r.addr == off);
  endfunction

  function automatic logic [3:0] pre_ratio(input logic [1:0] sel);
    case (sel)
      2'b00:   pre_ratio = PTS_PRE_LAST_1;
      2'b01:   pre_ratio = PTS_PRE_LAST_4;
      default: pre_ratio = PTS_PRE_LAST_16;
    endcase
  endfunction

  assign wr_count   = hit(bus_req, PTS_OFF_COUNT);
  assign wr_period  = hit(bus_req, PTS_OFF_PERIOD);
  assign wr_control = hit(bus_req, PTS_OFF_CONTROL);
  assign scaler_clear = wr_count || wr_control;
  assign pre_last   = pre_ratio(ctrl.prescale_select);
  assign at_period  = (timer_count == period_value);

  // ==========================================================================
  // Instruction clock divider and scalers
  always_comb begin
    next_insn = insn_cnt;
    insn_tick = 1'b0;
    if (ctrl.timer_on) begin
      if (insn_cnt == PTS_INSN_LAST) begin
        next_insn = 2'h0;
        insn_tick = 1'b1;
      end else begin
        next_insn = insn_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      insn_cnt <= 2'h0;
    end else begin
      insn_cnt <= next_insn;
    end
  end

  pts_scaler u_pre (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clear   (scaler_clear),
    .tick    (insn_tick),
    .last    (pre_last),
    .fire    (pre_fire)
  );

  // Match event is the increment on which the count wraps to zero
  assign match_pulse = pre_fire && at_period && !wr_count;

  pts_scaler u_post (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clear   (scaler_clear),
    .tick    (match_pulse),
    .last    (ctrl.postscale_select),
    .fire    (post_fire)
  );

  // ==========================================================================
  // Count, period and control registers
  always_comb begin
    next_count  = timer_count;
    next_period = period_value;
    next_ctrl   = ctrl;
    if (wr_count) begin
      next_count = bus_req.wdata;
    end else if (pre_fire) begin
      next_count = at_period ? PTS_COUNT_RST
                             : timer_count + 8'h01;
    end
    if (wr_period) begin
      next_period = bus_req.wdata;
    end
    if (wr_control) begin
      // Count is deliberately not touched here
      next_ctrl = pts_ctrl_t'(bus_req.wdata[PTS_POST_MSB:PTS_PRE_LSB]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      timer_count  <= PTS_COUNT_RST;
      period_value <= PTS_PERIOD_RST;
      ctrl         <= pts_ctrl_t'(PTS_CONTROL_RST[PTS_POST_MSB:0]);
    end else begin
      timer_count  <= next_count;
      period_value <= next_period;
      ctrl         <= next_ctrl;
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  always_comb begin
    next_status = status;
    next_mask   = mask;
    if (hit(bus_req, PTS_OFF_STATUS) && bus_req.wdata[0]) begin
      next_status = 1'b0;
    end
    // Set wins over a same-cycle clear so no event is lost
    if (post_fire) begin
      next_status = 1'b1;
    end
    if (hit(bus_req, PTS_OFF_MASK)) begin
      next_mask = bus_req.wdata[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      status <= 1'b0;
      mask   <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
    end
  end

  assign match_interrupt_flag = status;
  assign irq = status && mask;

  // ==========================================================================
  // Read port, data in the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        PTS_OFF_COUNT:   next_rdata = timer_count;
        PTS_OFF_PERIOD:  next_rdata = period_value;
        PTS_OFF_CONTROL: next_rdata = {1'b0, ctrl};
        PTS_OFF_STATUS:  next_rdata = {7'h00, status};
        PTS_OFF_MASK:    next_rdata = {7'h00, mask};
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

// ### tb/pts_timer_props.sv
// Checker for the period timer: timing relations seen at its ports.
// Assumes it is bound into pts_timer and sees only that module's ports.
`timescale 1ns/1ps
module pts_timer_props (
  input wire logic                  clk_sys,
  input wire logic                  nrst,
  input wire pts_pkg::pts_bus_req_t bus_req,
  input wire logic [7:0]   rdata,
  input wire logic         match_pulse,
  input wire logic         match_interrupt_flag,
  input wire logic         irq
);
  import pts_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ======
  // Register port
  a_rdata_idle_zero: assert property (
    !$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (
    bus_req.rd && bus_req.addr > PTS_OFF_MASK |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_top_zero: assert property (
    bus_req.rd && bus_req.addr == PTS_OFF_CONTROL |=> rdata[7] == 1'b0)
    else $error("control bit 7 not zero");
  a_period_write_read: assert property (
    bus_req.wr && bus_req.addr == PTS_OFF_PERIOD ##1 !bus_req.wr ##1
    bus_req.rd && bus_req.addr == PTS_OFF_PERIOD
    |=> rdata == $past(bus_req.wdata, 3))
    else $error("period read differs from write");
  // ======
  // Match and flag
  a_pulse_spacing: assert property (
    match_pulse |=> !match_pulse [*3])
    else $error("match pulses closer than one instruction clock");
  a_flag_from_match: assert property (
    $rose(match_interrupt_flag) |-> $past(match_pulse))
    else $error("flag rose without a match");
  a_flag_sticky: assert property (
    match_interrupt_flag && !(bus_req.wr && bus_req.wdata[0] &&
    bus_req.addr == PTS_OFF_STATUS) |=> match_interrupt_flag)
    else $error("flag dropped without a clear");
  a_irq_needs_flag: assert property (
    irq |-> match_interrupt_flag)
    else $error("interrupt without flag");
  a_irq_on_unmask: assert property (
    match_interrupt_flag && bus_req.wr && bus_req.addr == PTS_OFF_MASK &&
    bus_req.wdata[0] |=> irq)
    else $error("interrupt missing after unmask");
  a_flag_clears: assert property (
    bus_req.wr && bus_req.addr == PTS_OFF_STATUS && bus_req.wdata[0] &&
    !match_pulse |=> !match_interrupt_flag && !irq)
    else $error("flag or interrupt kept after clear");
endmodule

bind pts_timer pts_timer_props pts_timer_props_i (.clk_sys(clk_sys),
  .nrst(nrst), .bus_req(bus_req), .rdata(rdata), .match_pulse(match_pulse),
  .match_interrupt_flag(match_interrupt_flag), .irq(irq));

// ### tb/pts_timer_tb.sv
// Self-checking bench for the period timer: registers, match timing,
// postscaler count, interrupt masking and stop.
// Assumes the checker file is compiled alongside the design.
`timescale 1ns/1ps
module pts_timer_tb;
  import pts_pkg::*;
  logic         clk_sys;
  logic         nrst = 1'b0;
  pts_bus_req_t bus_req = '0;
  logic [7:0]   rdata, got, d;
  logic         match_pulse, match_interrupt_flag, irq;
  logic [31:0]  seed = 32'h7341;
  int           bad_count = 0, total_checks = 0;

  pts_timer pts_timer_i (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req),
    .rdata(rdata), .match_pulse(match_pulse), .irq(irq),
    .match_interrupt_flag(match_interrupt_flag));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Cycles to the flag: 4 per instruction tick, wrap after period + 1
  function automatic int exp_delay(logic [1:0] ps, logic [3:0] po,
                                   logic [7:0] p);
    return 4 * (ps[1] ? 16 : ps[0] ? 4 : 1) * (p + 1) * (po + 1);
  endfunction
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Insn divider phase survives writes, so the delay gets a small window
  task automatic run_timer(logic [1:0] ps, logic [3:0] po, logic [7:0] p);
    int n;
    int m;
    int e;
    n = 0;
    m = 0;
    e = exp_delay(ps, po, p);
    wr(PTS_OFF_CONTROL, 8'h00);
    wr(PTS_OFF_STATUS, 8'h01);
    wr(PTS_OFF_PERIOD, p);
    wr(PTS_OFF_COUNT, 8'h00);
    wr(PTS_OFF_CONTROL, {1'b0, po, 1'b1, ps});
    while (match_interrupt_flag !== 1'b1 && n < e + 40) begin
      @(negedge clk_sys);
      n++;
      if (match_pulse === 1'b1)
        m++;
    end
    chk("flag delay", 8'(n >= e - 4 && n <= e + 8), 8'h01);
    chk("match count", 8'(m), 8'(po + 1));
    $display("run pre %0d post %0d period %0d done", ps, po, p);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #900000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      chk("reset value", got, (a == 1) ? 8'hff : 8'h00);
    end
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hff : 8'(rnd());
      wr(PTS_OFF_PERIOD, d);
      rd(PTS_OFF_PERIOD);
      chk("period", got, d);
      wr(PTS_OFF_COUNT, d);
      wr(PTS_OFF_CONTROL, d & 8'hfb);
      rd(PTS_OFF_CONTROL);
      chk("control", got, d & 8'h7b);
      rd(PTS_OFF_COUNT);
      chk("count kept", got, d);
      wr(3'h7, d);
      rd(3'h7);
      chk("unmapped", got, 8'h00);
    end
    $display("register test done");
    for (int ps = 0; ps < 4; ps++)
      run_timer(2'(ps), 4'(rnd()), 8'(rnd() % 8));
    run_timer(2'b00, 4'hf, 8'h00);
    wr(PTS_OFF_CONTROL, 8'h00);
    rd(PTS_OFF_COUNT);
    d = got;
    repeat (100) @(posedge clk_sys);
    rd(PTS_OFF_COUNT);
    chk("count held", got, d);
    // A count write mid-prescale must restart the divide by 16
    wr(PTS_OFF_PERIOD, 8'hff);
    wr(PTS_OFF_COUNT, 8'h00);
    wr(PTS_OFF_CONTROL, 8'h06);
    repeat (40) @(posedge clk_sys);
    wr(PTS_OFF_COUNT, 8'h00);
    repeat (48) @(posedge clk_sys);
    rd(PTS_OFF_COUNT);
    chk("prescale cleared", got, 8'h00);
    repeat (24) @(posedge clk_sys);
    rd(PTS_OFF_COUNT);
    chk("prescale restart", got, 8'h01);
    wr(PTS_OFF_CONTROL, 8'h00);
    chk("irq masked", 8'(irq), 8'h00);
    wr(PTS_OFF_MASK, 8'h01);
    #1 chk("irq set", 8'(irq), 8'h01);
    rd(PTS_OFF_STATUS);
    chk("status", got, 8'h01);
    wr(PTS_OFF_STATUS, 8'h01);
    #1 chk("flag clear", 8'(match_interrupt_flag), 8'h00);
    chk("irq clear", 8'(irq), 8'h00);
    $display("interrupt test done");
    report_and_stop();
  end
endmodule
